// File: rtl/down_timers_pkg.sv
// package: register map, field positions and timing constants of the timers
package down_timers_pkg;
	localparam int          NUM_TIMERS     = 3;
	localparam int          COUNT_W        = 16;
	localparam int          BYTE_W         = 8;
	localparam int          ADDR_W         = 12;
	// register indices (printed offsets), byte address is four times these
	localparam logic [7:0]  IDX_T0_CFG     = 8'hB0;
	localparam logic [7:0]  IDX_T0_HIGH    = 8'hB1;
	localparam logic [7:0]  IDX_T0_LOW     = 8'hB2;
	localparam logic [7:0]  IDX_T1_CFG     = 8'hB3;
	localparam logic [7:0]  IDX_T1_HIGH    = 8'hB4;
	localparam logic [7:0]  IDX_T1_LOW     = 8'hB5;
	localparam logic [7:0]  IDX_T2_CFG     = 8'hB6;
	localparam logic [7:0]  IDX_T2_HIGH    = 8'hB7;
	localparam logic [7:0]  IDX_T2_LOW     = 8'hB8;
	localparam logic [7:0]  IDX_EVT_STATUS = 8'hB9;
	localparam logic [7:0]  IDX_EVT_MASK   = 8'hBA;
	localparam logic [7:0]  IDX_STRIDE     = 8'h03;
	localparam int          IDX_SHIFT      = 2;
	// configuration fields
	localparam int          CFG_RUN_BIT    = 0;
	localparam int          CFG_ONESHOT_BIT = 1;
	localparam int          CFG_CLOCK_SOURCE_SELECT_BIT = 2;
	localparam int          CFG_W          = 3;
	localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
	localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
	// 32 kHz tick timing
	localparam int          PCLK_HZ        = 40_000_000;
	localparam int          SLOW_HZ        = 32_000;
	localparam int          SLOW_DIV       = PCLK_HZ / SLOW_HZ;
endpackage : down_timers_pkg

// File: rtl/slow_tick_sync.sv
// module: three-stage synchroniser and edge detector for the 32 kHz clock
`timescale 1ns/100ps
module slow_tick_sync
	import down_timers_pkg::*;
(
	input  wire logic pclk,      // bus clock
	input  wire logic presetn,   // async reset, active low
	input  wire logic slow_clk,  // free 32 kHz clock from outside
	output logic      slow_tick  // one pulse per slow rising edge
);
	logic [2:0] sync_reg;    // three-flop chain
	logic [2:0] sync_next;   // next chain value
	logic       level_reg;   // level once stages two and three agree
	logic       level_next;  // next agreed level
	logic       tick_next;   // next tick value

	// shift the pin in; a change counts once stages two and three agree
	always_comb
	begin
		sync_next  = {sync_reg[1:0], slow_clk};
		level_next = level_reg;
		if (sync_reg[1] == sync_reg[2])
			level_next = sync_reg[2];  // both late stages settled
		tick_next  = level_next & ~level_reg;
	end

	// register chain and tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_reg  <= 3'h0;
			level_reg <= 1'b0;
			slow_tick <= 1'b0;
		end
		else
		begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
			slow_tick <= tick_next;
		end
	end
endmodule : slow_tick_sync

// File: rtl/down_counter.sv
// module: one 16-bit down counter with reload and one-shot stop
`timescale 1ns/100ps
module down_counter
	import down_timers_pkg::*;
#(
	parameter int WIDTH = COUNT_W  // counter width
)
(
	input  wire logic             pclk,      // bus clock
	input  wire logic             presetn,   // async reset, active low
	input  wire logic             run,       // run control bit
	input  wire logic             one_shot,  // one-shot mode select
	input  wire logic             step,      // count enable pulse
	input  wire logic [WIDTH-1:0] reload,    // reload value
	output logic      [WIDTH-1:0] count,     // current count
	output logic                  terminal   // pulse on reaching zero
);
	logic [WIDTH-1:0] count_next;    // next count
	logic             loaded_reg;    // count has been loaded since start
	logic             loaded_next;   // next loaded flag
	logic             term_next;     // next terminal pulse
	logic             done_reg;      // one-shot period has finished
	logic             done_next;     // next done flag

	// counting: follows reload while stopped, load on start, down on each step
	always_comb
	begin
		count_next  = count;
		loaded_next = loaded_reg;
		done_next   = done_reg;
		term_next   = 1'b0;
		if (!run)
		begin
			count_next  = reload;
			loaded_next = 1'b0;
			done_next   = 1'b0;
		end
		else if (!loaded_reg)
		begin
			count_next  = reload;
			loaded_next = 1'b1;
		end
		// a finished one-shot rests until run falls
		else if (step && !done_reg)
		begin
			if (count == COUNT_ONE[WIDTH-1:0] || count == '0)
			begin
				term_next = 1'b1;
				if (one_shot)
				begin
					count_next = '0;
					done_next  = 1'b1;
				end
				else
					count_next = reload;
			end
			else
				count_next = count - COUNT_ONE[WIDTH-1:0];
		end
	end

	// register counter state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count      <= '0;
			loaded_reg <= 1'b0;
			done_reg   <= 1'b0;
			terminal   <= 1'b0;
		end
		else
		begin
			count      <= count_next;
			loaded_reg <= loaded_next;
			done_reg   <= done_next;
			terminal   <= term_next;
		end
	end

	// a terminal pulse comes only from a running counter after a step
	property p_term_needs_run;
		@(posedge pclk) disable iff (!presetn)
		terminal |-> $past(run) && $past(step);
	endproperty
	a_term_needs_run: assert property (p_term_needs_run)
		else $error("terminal pulse without run and step");

	// stopped counter sits on the reload value
	property p_held_stopped;
		@(posedge pclk) disable iff (!presetn)
		!run ##1 !run |-> count == $past(reload);
	endproperty
	a_held_stopped: assert property (p_held_stopped)
		else $error("stopped counter not held");

	// continuous terminal reloads
	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		terminal && !$past(one_shot) |-> count == $past(reload);
	endproperty
	a_reload: assert property (p_reload)
		else $error("continuous mode did not reload");

	// a step decrements a count above one
	property p_decrement;
		@(posedge pclk) disable iff (!presetn)
		run && loaded_reg && step && count > COUNT_ONE[WIDTH-1:0]
		##1 run |-> count == $past(count) - COUNT_ONE[WIDTH-1:0];
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("count did not step down by one");

	// a finished one-shot gives no further terminal pulse
	property p_oneshot_quiet;
		@(posedge pclk) disable iff (!presetn)
		done_reg && $past(done_reg) |-> !terminal;
	endproperty
	a_oneshot_quiet: assert property (p_oneshot_quiet)
		else $error("one-shot counted past its period");
endmodule : down_counter

// File: rtl/down_timers.sv
// module: three programmable down timers behind an apb slave
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module down_timers
	import down_timers_pkg::*;
#(
	parameter int N = NUM_TIMERS  // number of timers
)
(
	input  wire logic              pclk,      // bus and cpu clock
	input  wire logic              presetn,   // async reset, active low
	input  wire logic              slow_clk,  // 32 kHz clock input
	input  wire logic              psel,      // apb select
	input  wire logic              penable,   // apb access phase
	input  wire logic              pwrite,    // apb direction
	input  wire logic [ADDR_W-1:0] paddr,     // apb byte address
	input  wire logic [31:0]       pwdata,    // apb write data
	output logic      [31:0]       prdata,    // apb read data
	output logic                   pready,    // apb ready
	output logic                   pslverr,   // apb error
	output logic                   irq        // level interrupt
);
	// register kinds of a decoded address
	typedef enum {
		SEL_NONE,
		SEL_CFG,
		SEL_HIGH,
		SEL_LOW,
		SEL_STATUS,
		SEL_MASK
	} sel_kind_t;

	logic [CFG_W-1:0]   cfg_reg   [N];  // per-timer config bits
	logic [CFG_W-1:0]   cfg_next  [N];
	logic [BYTE_W-1:0]  high_reg  [N];  // reload high bytes
	logic [BYTE_W-1:0]  high_next [N];
	logic [BYTE_W-1:0]  low_reg   [N];  // reload low bytes
	logic [BYTE_W-1:0]  low_next  [N];
	logic [N-1:0]       status_reg;     // sticky terminal events
	logic [N-1:0]       status_next;
	logic [N-1:0]       mask_reg;       // event enables
	logic [N-1:0]       mask_next;
	logic [31:0]        prdata_next;
	logic               pready_next;
	logic               pslverr_next;
	logic               irq_next;
	logic [COUNT_W-1:0] count_w   [N];  // live counts
	logic [N-1:0]       term_w;         // terminal pulses
	logic               slow_tick;      // one pulse per 32 kHz rising edge
	sel_kind_t          kind;           // decoded register kind
	int                 tsel;           // decoded timer number
	logic               access;         // apb access phase cycle
	logic               addr_ok;        // word aligned address

	// map a register index to its kind
	function automatic sel_kind_t idx_kind(input logic [7:0] idx);
		sel_kind_t k;
		k = SEL_NONE;
		if (idx >= IDX_T0_CFG && idx <= IDX_T2_LOW)
		begin
			unique case ((idx - IDX_T0_CFG) % IDX_STRIDE)
				8'h00: k = SEL_CFG;
				8'h01: k = SEL_HIGH;
				default: k = SEL_LOW;
			endcase
		end
		else if (idx == IDX_EVT_STATUS)
			k = SEL_STATUS;
		else if (idx == IDX_EVT_MASK)
			k = SEL_MASK;
		return k;
	endfunction : idx_kind

	// map a register index to its timer number
	function automatic int idx_timer(input logic [7:0] idx);
		logic [7:0] off;
		off = idx - IDX_T0_CFG;
		return int'(off / IDX_STRIDE);
	endfunction : idx_timer

	// slow clock crossing into pclk
	slow_tick_sync u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.slow_clk  (slow_clk),
		.slow_tick (slow_tick)
	);

	// one counter per timer, each on its own settings
	generate
		for (genvar g = 0; g < N; g++)
		begin : g_timer
			down_counter #(.WIDTH(COUNT_W)) u_cnt (
				.pclk     (pclk),
				.presetn  (presetn),
				.run      (cfg_reg[g][CFG_RUN_BIT]),
				.one_shot (cfg_reg[g][CFG_ONESHOT_BIT]),
				// select cpu clock or the 32 kHz tick
				.step     (cfg_reg[g][CFG_CLOCK_SOURCE_SELECT_BIT] ? 1'b1
				           : slow_tick),
				.reload   ({high_reg[g], low_reg[g]}),
				.count    (count_w[g]),
				.terminal (term_w[g])
			);
		end
	endgenerate

	// address decode
	always_comb
	begin
		// aligned, and no address bits above the index field
		addr_ok = (paddr[IDX_SHIFT-1:0] == 2'h0)
		          && (paddr[ADDR_W-1:IDX_SHIFT+BYTE_W] == '0);
		kind    = addr_ok
		          ? idx_kind(paddr[IDX_SHIFT+BYTE_W-1:IDX_SHIFT])
		          : SEL_NONE;
		tsel    = idx_timer(paddr[IDX_SHIFT+BYTE_W-1:IDX_SHIFT]);
		access  = psel && penable && !pready;
	end

	// next register values, bus answer and events
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			cfg_next[i]  = cfg_reg[i];
			high_next[i] = high_reg[i];
			low_next[i]  = low_reg[i];
		end
		mask_next    = mask_reg;
		status_next  = status_reg;
		prdata_next  = prdata;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (access)
		begin
			pready_next  = 1'b1;
			pslverr_next = (kind == SEL_NONE);
			prdata_next  = RDATA_ZERO;
			if (pwrite)
			begin
				unique case (kind)
					// reserved bits are dropped; software writes zero
					SEL_CFG:    cfg_next[tsel] =
					            pwdata[CFG_W-1:0];
					SEL_HIGH:   high_next[tsel] = pwdata[BYTE_W-1:0];
					SEL_LOW:    low_next[tsel] = pwdata[BYTE_W-1:0];
					SEL_MASK:   mask_next = pwdata[N-1:0];
					SEL_STATUS: ;
					SEL_NONE:   ;
				endcase
			end
			else
			begin
				unique case (kind)
					SEL_CFG:    prdata_next[CFG_W-1:0] = cfg_reg[tsel];
					SEL_HIGH:   prdata_next[BYTE_W-1:0] = high_reg[tsel];
					SEL_LOW:    prdata_next[BYTE_W-1:0] = low_reg[tsel];
					SEL_MASK:   prdata_next[N-1:0] = mask_reg;
					SEL_STATUS:
					begin
						prdata_next[N-1:0] = status_reg;
						status_next = '0;  // read clears
					end
					SEL_NONE:   ;
				endcase
			end
		end
		// one-shot completion stops the timer; hardware wins over writes
		for (int i = 0; i < N; i++)
		begin
			if (term_w[i] && cfg_reg[i][CFG_ONESHOT_BIT])
				cfg_next[i][CFG_RUN_BIT] = 1'b0;
			if (term_w[i])
				status_next[i] = 1'b1;  // set beats clear
		end
		irq_next = |(status_next & mask_next);
	end

	// register everything
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < N; i++)
			begin
				cfg_reg[i]  <= CFG_RESET;
				high_reg[i] <= BYTE_RESET;
				low_reg[i]  <= BYTE_RESET;
			end
			status_reg <= '0;
			mask_reg   <= '0;
			prdata     <= RDATA_ZERO;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			irq        <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				cfg_reg[i]  <= cfg_next[i];
				high_reg[i] <= high_next[i];
				low_reg[i]  <= low_next[i];
			end
			status_reg <= status_next;
			mask_reg   <= mask_next;
			prdata     <= prdata_next;
			pready     <= pready_next;
			pslverr    <= pslverr_next;
			irq        <= irq_next;
		end
	end

	// one-shot terminal clears run on the next edge
	property p_oneshot_stop;
		@(posedge pclk) disable iff (!presetn)
		term_w[0] && cfg_reg[0][CFG_ONESHOT_BIT] |=>
		!cfg_reg[0][CFG_RUN_BIT];
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop)
		else $error("one-shot did not clear run");

	// a terminal event leaves its status bit set
	property p_event_sticky;
		@(posedge pclk) disable iff (!presetn)
		term_w[1] |=> status_reg[1];
	endproperty
	a_event_sticky: assert property (p_event_sticky)
		else $error("terminal event not recorded");

	// one-shot gives no terminal pulse in the cycle after it stopped
	property p_oneshot_once;
		@(posedge pclk) disable iff (!presetn)
		term_w[2] && cfg_reg[2][CFG_ONESHOT_BIT] ##1
		!cfg_reg[2][CFG_RUN_BIT] |-> !term_w[2];
	endproperty
	a_oneshot_once: assert property (p_oneshot_once)
		else $error("one-shot terminal repeated");

	// ready stays one cycle only
	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready longer than one cycle");

	// interrupt tracks masked status
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq == |(status_reg & mask_reg);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq disagrees with status and mask");

	// an error answer comes only with ready
	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("pslverr without pready");

	// every access phase is answered on the next edge
	property p_ready_after_access;
		@(posedge pclk) disable iff (!presetn)
		access |=> pready;
	endproperty
	a_ready_after_access: assert property (p_ready_after_access)
		else $error("access phase not answered");

	// an unmapped or unaligned address is refused
	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		access && kind == SEL_NONE |=> pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not refused");

	// a mapped register answers without error
	property p_mapped_ok;
		@(posedge pclk) disable iff (!presetn)
		access && kind != SEL_NONE |=> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok)
		else $error("mapped access refused");

	// the third timer's config register takes a write
	property p_cfg2_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && kind == SEL_CFG && tsel == 2 && !term_w[2]
		|=> cfg_reg[2] == $past(pwdata[CFG_W-1:0]);
	endproperty
	a_cfg2_write: assert property (p_cfg2_write)
		else $error("timer 2 config write lost");

	// a high byte write lands in the upper reload byte
	property p_high_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && kind == SEL_HIGH && tsel == 1
		|=> high_reg[1] == $past(pwdata[BYTE_W-1:0]);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("high byte write lost");

	// a low byte write lands in the lower reload byte
	property p_low_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && kind == SEL_LOW && tsel == 0
		|=> low_reg[0] == $past(pwdata[BYTE_W-1:0]);
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low byte write lost");

	// the mask register takes a write
	property p_mask_write;
		@(posedge pclk) disable iff (!presetn)
		access && pwrite && kind == SEL_MASK
		|=> mask_reg == $past(pwdata[N-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write lost");

	// a status read with no new event leaves it clear
	property p_status_clear;
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && kind == SEL_STATUS && !(|term_w)
		|=> status_reg == '0;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status read did not clear");

	// a stopped timer gives no terminal pulse
	property p_stopped_quiet;
		@(posedge pclk) disable iff (!presetn)
		!cfg_reg[0][CFG_RUN_BIT] |=> !term_w[0];
	endproperty
	a_stopped_quiet: assert property (p_stopped_quiet)
		else $error("stopped timer reached terminal count");

	// a status bit stays set until software reads it
	property p_status_holds;
		@(posedge pclk) disable iff (!presetn)
		status_reg[2] && !(access && !pwrite && kind == SEL_STATUS)
		|=> status_reg[2];
	endproperty
	a_status_holds: assert property (p_status_holds)
		else $error("status bit lost without a read");

	// a config read returns the stored bits
	property p_read_cfg2;
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && kind == SEL_CFG && tsel == 2
		|=> prdata[CFG_W-1:0] == $past(cfg_reg[2]);
	endproperty
	a_read_cfg2: assert property (p_read_cfg2)
		else $error("config read data wrong");
endmodule : down_timers

// File: tb/test_down_timers.sv
// testbench: self-checking run of the three down timers over apb
`timescale 1ns/100ps
module test_down_timers import down_timers_pkg::*;;
	logic              pclk;          // bus clock
	logic              presetn;       // reset, active low
	logic              slow_clk;      // free slow clock
	logic              psel;          // apb select
	logic              penable;       // apb access phase
	logic              pwrite;        // apb direction
	logic [ADDR_W-1:0] paddr;         // apb byte address
	logic [31:0]       pwdata;        // apb write data
	logic [31:0]       prdata;        // apb read data
	logic              pready;        // apb ready
	logic              pslverr;       // apb error
	logic              irq;           // level interrupt
	logic [31:0]       mdl [256];     // register model by index
	logic [31:0]       seed;          // xorshift state
	logic [7:0]        base;          // config index of a timer
	int                slow_cnt;      // half period counter of slow clock
	int                cycles;        // timeout counter
	int                miscompares;   // mismatches seen
	int                total_checks;  // comparisons made

	// device under test
	down_timers down_timers_i (
		.pclk    (pclk),
		.presetn (presetn),
		.slow_clk(slow_clk),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.irq     (irq)
	);

	// bus clock, 25 ns period
	always #12.5 pclk = ~pclk;

	// slow clock, one toggle every half of the divider
	always @(posedge pclk)
	begin
		slow_cnt <= slow_cnt + 1;
		if (slow_cnt == SLOW_DIV / 2 - 1)
		begin
			slow_cnt <= 0;
			slow_clk <= ~slow_clk;
		end
	end

	// hang guard: a run that overstays counts as a mismatch
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report();
		end
	end

	// count totals, print verdict and stop
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// compare one value with its expectation
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// xorshift source of stimulus data
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// index lies inside the register map
	function automatic logic mapped(input logic [7:0] idx);
		return idx >= IDX_T0_CFG && idx <= IDX_EVT_MASK;
	endfunction : mapped

	// one apb transfer: setup, access held until pready
	task automatic apb(input logic [7:0] idx, input logic wr,
		input logic [31:0] wd, output logic [31:0] d, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		chk(n, 32'h2);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// write a register and mirror it in the model
	task automatic bus_wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		logic        e;
		apb(idx, 1'b1, wd, d, e);
		chk({31'h0, e}, {31'h0, !mapped(idx)});
		if (idx == IDX_T0_CFG || idx == IDX_T1_CFG || idx == IDX_T2_CFG
			|| idx == IDX_EVT_MASK)
			mdl[idx] = wd & 32'h0000_0007;
		else if (mapped(idx) && idx != IDX_EVT_STATUS)
			mdl[idx] = wd & 32'h0000_00FF;
	endtask : bus_wr

	// read a register, compare when asked; status clears on read
	task automatic bus_rd(input logic [7:0] idx, input logic cmp);
		logic [31:0] d;
		logic        e;
		apb(idx, 1'b0, 32'h0, d, e);
		chk({31'h0, e}, {31'h0, !mapped(idx)});
		if (cmp)
			chk(d, mapped(idx) ? mdl[idx] : 32'h0);
		if (idx == IDX_EVT_STATUS)
			mdl[idx] = 32'h0;
	endtask : bus_rd

	// interrupt level against masked model status
	task automatic irq_chk();
		repeat (2) @(posedge pclk);
		chk({31'h0, irq},
			{31'h0, |(mdl[IDX_EVT_STATUS] & mdl[IDX_EVT_MASK])});
	endtask : irq_chk

	// main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		slow_clk = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		seed = 32'h37EDAEC1;
		slow_cnt = 0;
		cycles = 0;
		miscompares = 0;
		total_checks = 0;
		for (int i = 0; i < 256; i++)
			mdl[i] = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset values of all registers plus one unmapped slot
		for (int i = 0; i < 12; i++)
			bus_rd(IDX_T0_CFG + i[7:0], 1'b1);
		// random reload bytes, stopped one-shot config, read back
		for (int t = 0; t < 3; t++)
		begin
			base = IDX_T0_CFG + IDX_STRIDE * t[7:0];
			bus_wr(base + 8'h01, xs());
			bus_wr(base + 8'h02, xs());
			bus_wr(base, 32'h0000_0002);
		end
		for (int i = 0; i < 11; i++)
			bus_rd(IDX_T0_CFG + i[7:0], 1'b1);
		// stopped timers raise no event
		repeat (100) @(posedge pclk);
		bus_rd(IDX_EVT_STATUS, 1'b1);
		// timer 0 one-shot on the bus clock, reload 40
		bus_wr(IDX_T0_HIGH, 32'h0);
		bus_wr(IDX_T0_LOW, 32'h28);
		bus_wr(IDX_T0_CFG, 32'h7);
		bus_rd(IDX_T0_CFG, 1'b1);
		// forty steps from reload: no event yet after thirty cycles
		repeat (30) @(posedge pclk);
		bus_rd(IDX_EVT_STATUS, 1'b1);
		repeat (30) @(posedge pclk);
		mdl[IDX_T0_CFG] = 32'h6;
		mdl[IDX_EVT_STATUS] = 32'h1;
		bus_rd(IDX_T0_CFG, 1'b1);
		irq_chk();
		bus_wr(IDX_EVT_MASK, 32'h7);
		irq_chk();
		bus_rd(IDX_EVT_STATUS, 1'b1);
		irq_chk();
		// timer 1 continuous on the bus clock, reload 20
		bus_wr(IDX_T1_HIGH, 32'h0);
		bus_wr(IDX_T1_LOW, 32'h14);
		bus_wr(IDX_T1_CFG, 32'h5);
		repeat (40) @(posedge pclk);
		mdl[IDX_EVT_STATUS] = 32'h2;
		bus_rd(IDX_EVT_STATUS, 1'b1);
		repeat (30) @(posedge pclk);
		mdl[IDX_EVT_STATUS] = 32'h2;
		bus_rd(IDX_EVT_STATUS, 1'b1);
		bus_rd(IDX_T1_CFG, 1'b1);
		// stop it, flush status, then nothing new arrives
		bus_wr(IDX_T1_CFG, 32'h4);
		bus_rd(IDX_EVT_STATUS, 1'b0);
		// status is read-only: a write must not set it
		bus_wr(IDX_EVT_STATUS, 32'h7);
		repeat (50) @(posedge pclk);
		bus_rd(IDX_EVT_STATUS, 1'b1);
		irq_chk();
		// timer 2 one-shot on the slow clock, reload 2
		bus_wr(IDX_T2_HIGH, 32'h0);
		bus_wr(IDX_T2_LOW, 32'h2);
		bus_wr(IDX_T2_CFG, 32'h3);
		repeat (200) @(posedge pclk);
		bus_rd(IDX_T2_CFG, 1'b1);
		bus_rd(IDX_EVT_STATUS, 1'b1);
		repeat (4000) @(posedge pclk);
		mdl[IDX_T2_CFG] = 32'h2;
		mdl[IDX_EVT_STATUS] = 32'h4;
		irq_chk();
		bus_rd(IDX_T2_CFG, 1'b1);
		bus_rd(IDX_EVT_STATUS, 1'b1);
		final_report();
	end
endmodule : test_down_timers
